// ---- hdl/ldar_params.svh ----
`ifndef LDAR_PARAMS_SVH
`define LDAR_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define LDAR_OFS_ALARM_SETUP_CH2 8'h0d
`define LDAR_OFS_CODE_CH2_HIGH 8'h10
`define LDAR_OFS_CODE_CH2_LOW 8'h11
`define LDAR_OFS_FS_CH2 8'h12
`define LDAR_OFS_FS_CH2_LP 8'h13
`define LDAR_OFS_CODE_CH1_HIGH 8'h14
`define LDAR_OFS_CODE_CH1_LOW 8'h15

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LDAR_RST_ALARM_SETUP_CH2 8'h31
`define LDAR_RST_CODE_CH2_HIGH 8'h00
`define LDAR_RST_CODE_CH2_LOW 8'h00
`define LDAR_RST_FS_CH2 8'h3f
`define LDAR_RST_FS_CH2_LP 8'h3f
`define LDAR_RST_CODE_CH1_HIGH 8'h00
`define LDAR_RST_CODE_CH1_LOW 8'h00

// ----------------------------------------------------------------
// Field positions in the alarm setup register
// ----------------------------------------------------------------
`define LDAR_BIT_POWERDOWN 0
`define LDAR_LSB_TRIP_LEVEL 1
`define LDAR_MSB_TRIP_LEVEL 2
`define LDAR_BIT_FILTER_SEL 3
`define LDAR_LSB_TURNON_DELAY 4
`define LDAR_MSB_TURNON_DELAY 5

// ----------------------------------------------------------------
// Trip levels in millivolts
// ----------------------------------------------------------------
`define LDAR_TRIP_MV_0 8'hc8
`define LDAR_TRIP_MV_1 8'h96
`define LDAR_TRIP_MV_2 8'h64
`define LDAR_TRIP_MV_3 8'h32

// ----------------------------------------------------------------
// Full-scale current mapping, milliamps
// ----------------------------------------------------------------
`define LDAR_FS_MIN_MA 200
`define LDAR_FS_SPAN_MA 1800
`define LDAR_FS_MAX_CODE 63

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LDAR_CLK_NS 25
`define LDAR_FILTER_LONG_NS 5000
`define LDAR_FILTER_SHORT_NS 2000
`define LDAR_FILTER_LONG_CYC \
  ((`LDAR_FILTER_LONG_NS + `LDAR_CLK_NS - 1) / `LDAR_CLK_NS)
`define LDAR_FILTER_SHORT_CYC \
  ((`LDAR_FILTER_SHORT_NS + `LDAR_CLK_NS - 1) / `LDAR_CLK_NS)

`endif

// ---- hdl/ldar_pkg.sv ----
`default_nettype none

package ldar_pkg;
  typedef logic [7:0] ldar_byte_t;
  typedef logic [9:0] ldar_code_t;
  typedef logic [5:0] ldar_scale_t;
  typedef logic [1:0] ldar_level_t;
  typedef logic [11:0] ldar_ma_t;
endpackage

`default_nettype wire

// ---- hdl/ldar_alarm_filter.sv ----
`include "ldar_params.svh"
`default_nettype none

module ldar_alarm_filter #(
  parameter int CNT_W = 8,
  parameter logic [7:0] LONG_CYC = 8'(`LDAR_FILTER_LONG_CYC),
  parameter logic [7:0] SHORT_CYC = 8'(`LDAR_FILTER_SHORT_CYC)
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic trip_in,
  input wire logic powerdown_in,
  input wire logic long_sel_in,
  output logic alarm_out
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] target;

  // ----------------------------------------------------------------
  // Time constant select
  // ----------------------------------------------------------------
  assign target = long_sel_in ? CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);

  // ----------------------------------------------------------------
  // Persistence counter
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_q <= '0;
    end else if (powerdown_in || !trip_in) begin
      cnt_q <= '0;
    end else if (cnt_q < target) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_out <= 1'b0;
    end else begin
      alarm_out <= !powerdown_in && trip_in && (cnt_q >= target);
    end
  end

endmodule

`default_nettype wire

// ---- hdl/ldar_regs.sv ----
`include "ldar_params.svh"
`default_nettype none

module ldar_regs (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  input wire logic low_power_select_n_in,
  input wire logic ch2_alarm_trip_in,
  output logic [9:0] ch2_current_code_out,
  output logic [9:0] ch1_current_code_out,
  output logic [5:0] ch2_fullscale_field_out,
  output logic [11:0] ch2_fullscale_ma_out,
  output logic [1:0] ch2_alarm_trip_level_out,
  output logic [7:0] ch2_alarm_trip_mv_out,
  output logic ch2_alarm_filter_sel_out,
  output logic ch2_alarm_powerdown_out,
  output logic [1:0] ch2_alarm_turnon_delay_out,
  output logic ch2_alarm_out
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic ldar_pkg::ldar_ma_t scale_to_ma(
    input ldar_pkg::ldar_scale_t code
  );
    int unsigned ma;
    ma = `LDAR_FS_MIN_MA +
         (int'(code) * `LDAR_FS_SPAN_MA) / `LDAR_FS_MAX_CODE;
    return ma[11:0];
  endfunction

  function automatic ldar_pkg::ldar_byte_t level_to_mv(
    input ldar_pkg::ldar_level_t lvl
  );
    ldar_pkg::ldar_byte_t mv;
    unique case (lvl)
      2'h0: mv = `LDAR_TRIP_MV_0;
      2'h1: mv = `LDAR_TRIP_MV_1;
      2'h2: mv = `LDAR_TRIP_MV_2;
      2'h3: mv = `LDAR_TRIP_MV_3;
    endcase
    return mv;
  endfunction

  function automatic ldar_pkg::ldar_code_t join_code(
    input logic [1:0] hi,
    input ldar_pkg::ldar_byte_t lo
  );
    return {hi, lo};
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [5:0] alarm_setup_q;
  logic [1:0] code_ch2_high_q;
  ldar_pkg::ldar_byte_t code_ch2_low_q;
  ldar_pkg::ldar_scale_t fs_ch2_q;
  ldar_pkg::ldar_scale_t fs_ch2_lp_q;
  logic [1:0] code_ch1_high_q;
  ldar_pkg::ldar_byte_t code_ch1_low_q;

  ldar_pkg::ldar_byte_t rdata_d;
  ldar_pkg::ldar_scale_t scale_sel;
  logic lp_meta_q;
  logic lp_sync_q;
  logic trip_meta_q;
  logic trip_sync_q;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      alarm_setup_q <= 6'(`LDAR_RST_ALARM_SETUP_CH2);
    end else if (reg_wr_in &&
                 reg_addr_in == `LDAR_OFS_ALARM_SETUP_CH2) begin
      alarm_setup_q <= reg_wdata_in[5:0];
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      code_ch2_high_q <= 2'(`LDAR_RST_CODE_CH2_HIGH);
      code_ch2_low_q <= `LDAR_RST_CODE_CH2_LOW;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `LDAR_OFS_CODE_CH2_HIGH) begin
        code_ch2_high_q <= reg_wdata_in[1:0];
      end
      if (reg_addr_in == `LDAR_OFS_CODE_CH2_LOW) begin
        code_ch2_low_q <= reg_wdata_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fs_ch2_q <= 6'(`LDAR_RST_FS_CH2);
      fs_ch2_lp_q <= 6'(`LDAR_RST_FS_CH2_LP);
    end else if (reg_wr_in) begin
      if (reg_addr_in == `LDAR_OFS_FS_CH2) begin
        fs_ch2_q <= reg_wdata_in[5:0];
      end
      if (reg_addr_in == `LDAR_OFS_FS_CH2_LP) begin
        fs_ch2_lp_q <= reg_wdata_in[5:0];
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      code_ch1_high_q <= 2'(`LDAR_RST_CODE_CH1_HIGH);
      code_ch1_low_q <= `LDAR_RST_CODE_CH1_LOW;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `LDAR_OFS_CODE_CH1_HIGH) begin
        code_ch1_high_q <= reg_wdata_in[1:0];
      end
      if (reg_addr_in == `LDAR_OFS_CODE_CH1_LOW) begin
        code_ch1_low_q <= reg_wdata_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  // Reserved bits and unmapped offsets read as zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_addr_in)
      `LDAR_OFS_ALARM_SETUP_CH2: rdata_d = {2'h0, alarm_setup_q};
      `LDAR_OFS_CODE_CH2_HIGH: rdata_d = {6'h00, code_ch2_high_q};
      `LDAR_OFS_CODE_CH2_LOW: rdata_d = code_ch2_low_q;
      `LDAR_OFS_FS_CH2: rdata_d = {2'h0, fs_ch2_q};
      `LDAR_OFS_FS_CH2_LP: rdata_d = {2'h0, fs_ch2_lp_q};
      `LDAR_OFS_CODE_CH1_HIGH: rdata_d = {6'h00, code_ch1_high_q};
      `LDAR_OFS_CODE_CH1_LOW: rdata_d = code_ch1_low_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lp_meta_q <= 1'b1;
      lp_sync_q <= 1'b1;
    end else begin
      lp_meta_q <= low_power_select_n_in;
      lp_sync_q <= lp_meta_q;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      trip_meta_q <= 1'b0;
      trip_sync_q <= 1'b0;
    end else begin
      trip_meta_q <= ch2_alarm_trip_in;
      trip_sync_q <= trip_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // Drive codes
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ch2_current_code_out <= 10'h000;
      ch1_current_code_out <= 10'h000;
    end else begin
      ch2_current_code_out <= join_code(code_ch2_high_q,
                                        code_ch2_low_q);
      ch1_current_code_out <= join_code(code_ch1_high_q,
                                        code_ch1_low_q);
    end
  end

  // ----------------------------------------------------------------
  // Full-scale selection
  // ----------------------------------------------------------------
  assign scale_sel = lp_sync_q ? fs_ch2_q : fs_ch2_lp_q;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ch2_fullscale_field_out <= 6'(`LDAR_RST_FS_CH2);
      ch2_fullscale_ma_out <= 12'h000;
    end else begin
      ch2_fullscale_field_out <= scale_sel;
      ch2_fullscale_ma_out <= scale_to_ma(scale_sel);
    end
  end

  // ----------------------------------------------------------------
  // Alarm setup fields
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ch2_alarm_trip_level_out <= 2'h0;
      ch2_alarm_trip_mv_out <= `LDAR_TRIP_MV_0;
      ch2_alarm_filter_sel_out <= 1'b0;
      ch2_alarm_powerdown_out <= 1'b1;
      ch2_alarm_turnon_delay_out <= 2'h3;
    end else begin
      ch2_alarm_trip_level_out <=
        alarm_setup_q[`LDAR_MSB_TRIP_LEVEL:`LDAR_LSB_TRIP_LEVEL];
      ch2_alarm_trip_mv_out <= level_to_mv(
        alarm_setup_q[`LDAR_MSB_TRIP_LEVEL:`LDAR_LSB_TRIP_LEVEL]);
      ch2_alarm_filter_sel_out <= alarm_setup_q[`LDAR_BIT_FILTER_SEL];
      ch2_alarm_powerdown_out <= alarm_setup_q[`LDAR_BIT_POWERDOWN];
      ch2_alarm_turnon_delay_out <=
        alarm_setup_q[`LDAR_MSB_TURNON_DELAY:`LDAR_LSB_TURNON_DELAY];
    end
  end

  // ----------------------------------------------------------------
  // Channel-2 alarm filter
  // ----------------------------------------------------------------
  ldar_alarm_filter u_filter (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .trip_in(trip_sync_q),
    .powerdown_in(alarm_setup_q[`LDAR_BIT_POWERDOWN]),
    .long_sel_in(alarm_setup_q[`LDAR_BIT_FILTER_SEL]),
    .alarm_out(ch2_alarm_out)
  );

endmodule

`default_nettype wire

// ---- sim/ldar_regs_monitor.sv ----
`default_nettype none
module ldar_regs_monitor (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic low_power_select_n_in,
  input wire logic ch2_alarm_trip_in,
  input wire logic [9:0] ch2_current_code_out,
  input wire logic [5:0] ch2_fullscale_field_out,
  input wire logic [11:0] ch2_fullscale_ma_out,
  input wire logic [1:0] ch2_alarm_trip_level_out,
  input wire logic [7:0] ch2_alarm_trip_mv_out,
  input wire logic ch2_alarm_filter_sel_out,
  input wire logic ch2_alarm_powerdown_out,
  input wire logic ch2_alarm_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic [5:0] fs_q, lp_q, exp_q;
  logic p1_q, p2_q;
  // ----------------------------------------------------------------
  // Expected active scale: two sync stages then the output register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      fs_q <= 6'h3f;
      lp_q <= 6'h3f;
      exp_q <= 6'h3f;
      p1_q <= 1'b1;
      p2_q <= 1'b1;
    end else begin
      if (reg_wr_in && reg_addr_in == 8'h12) fs_q <= reg_wdata_in[5:0];
      if (reg_wr_in && reg_addr_in == 8'h13) lp_q <= reg_wdata_in[5:0];
      p1_q <= low_power_select_n_in;
      p2_q <= p1_q;
      exp_q <= p2_q ? fs_q : lp_q;
    end
  end
  code_low_a: assert property (reg_wr_in && reg_addr_in == 8'h11 |->
    ##2 ch2_current_code_out[7:0] == $past(reg_wdata_in, 2))
    else $error("ch2 low code not loaded");
  code_high_a: assert property (reg_wr_in && reg_addr_in == 8'h10 |->
    ##2 ch2_current_code_out[9:8] == $past(reg_wdata_in[1:0], 2))
    else $error("ch2 high code not loaded");
  filter_sel_a: assert property (reg_wr_in && reg_addr_in == 8'h0d |->
    ##2 ch2_alarm_filter_sel_out == $past(reg_wdata_in[3], 2))
    else $error("filter select not loaded");
  power_down_a: assert property (reg_wr_in && reg_addr_in == 8'h0d |->
    ##2 ch2_alarm_powerdown_out == $past(reg_wdata_in[0], 2))
    else $error("powerdown not loaded");
  alarm_quiet_a: assert property (
    ch2_alarm_powerdown_out && $past(ch2_alarm_powerdown_out) |->
    !ch2_alarm_out)
    else $error("alarm high while powered down");
  alarm_wait_a: assert property ($rose(ch2_alarm_out) |->
    $past(ch2_alarm_trip_in, 78) &&
    (!ch2_alarm_filter_sel_out || $past(ch2_alarm_trip_in, 198)))
    else $error("alarm rose before filter time");
  full_ma_a: assert property (!$past(rst_in) |-> ch2_fullscale_ma_out ==
    12'(200 + ch2_fullscale_field_out * 1800 / 63))
    else $error("full scale current mismatch");
  scale_pick_a: assert property (ch2_fullscale_field_out == exp_q)
    else $error("wrong scale field selected");
  trip_mv_a: assert property (ch2_alarm_trip_mv_out ==
    8'(200 - 50 * ch2_alarm_trip_level_out))
    else $error("trip level voltage mismatch");
endmodule
`default_nettype wire

// ---- sim/ldar_host.sv ----
`default_nettype none
module ldar_host (
  input wire logic sys_clk_in,
  input wire logic [7:0] reg_rdata_in,
  input wire logic reg_rvalid_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // Released lines show inverted values, never the last ones
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    d = 8'hxx;
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_out <= 1'b0;
    reg_addr_out <= ~a;
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk_in);
      if (reg_rvalid_in === 1'b1) begin
        d = reg_rdata_in;
        break;
      end
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/ldar_regs_tb_top.sv ----
`default_nettype none
module ldar_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in, rst_in, reg_wr_in, reg_rd_in, reg_rvalid_out;
  logic low_power_select_n_in, ch2_alarm_trip_in, ch2_alarm_out;
  logic ch2_alarm_filter_sel_out, ch2_alarm_powerdown_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, ch2_alarm_trip_mv_out;
  logic [9:0] ch2_current_code_out, ch1_current_code_out;
  logic [5:0] ch2_fullscale_field_out;
  logic [11:0] ch2_fullscale_ma_out;
  logic [1:0] ch2_alarm_trip_level_out, ch2_alarm_turnon_delay_out;
  logic [31:0] seed = 32'h65ac;
  logic [7:0] got;
  int n_errors = 0, num_checks = 0, cyc = 0, n;
  logic [7:0] ofs [7] = '{8'h0d, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
  logic [7:0] rstv [7] = '{8'h31, 8'h00, 8'h00, 8'h3f, 8'h3f, 8'h00, 8'h00};
  logic [7:0] msk [7] = '{8'h3f, 8'h03, 8'hff, 8'h3f, 8'h3f, 8'h03, 8'hff};
  logic [7:0] fsc [4] = '{8'h00, 8'h01, 8'h1c, 8'h3f};
  logic [11:0] fma [4] = '{12'h0c8, 12'h0e4, 12'h3e8, 12'h7d0};
  logic [7:0] mvs [4] = '{8'hc8, 8'h96, 8'h64, 8'h32};
  logic [7:0] sh [7];
  ldar_regs dut_u (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out,
    .low_power_select_n_in, .ch2_alarm_trip_in, .ch2_current_code_out,
    .ch1_current_code_out, .ch2_fullscale_field_out, .ch2_fullscale_ma_out,
    .ch2_alarm_trip_level_out, .ch2_alarm_trip_mv_out,
    .ch2_alarm_filter_sel_out, .ch2_alarm_powerdown_out,
    .ch2_alarm_turnon_delay_out, .ch2_alarm_out);
  ldar_host host_u (.sys_clk_in, .reg_rdata_in(reg_rdata_out),
    .reg_rvalid_in(reg_rvalid_out), .reg_addr_out(reg_addr_in),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_wdata_out(reg_wdata_in));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: %s got %0h exp %0h", $time, m, g, e);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic wi(input int i, input logic [7:0] d);
    host_u.wr(ofs[i], d);
    sh[i] = d & msk[i];
  endtask
  task automatic ri(input int i);
    host_u.rd(ofs[i], got);
    chk(got, sh[i], "readback");
  endtask
  task automatic settle(input int c);
    repeat (c) @(posedge sys_clk_in);
  endtask
  initial begin
    sys_clk_in = 1'b0;
    forever #12.5 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    rst_in = 1'b1;
    low_power_select_n_in = 1'b1;
    ch2_alarm_trip_in = 1'b0;
    settle(8);
    rst_in <= 1'b0;
    sh = rstv;
    for (int i = 0; i < 7; i++) ri(i);
    host_u.wr(8'h0e, 8'hff);
    host_u.rd(8'h0e, got);
    chk(got, 8'h00, "unmapped");
    repeat (40) begin
      seed = xs(seed);
      wi(seed[10:8] % 7, seed[7:0]);
      low_power_select_n_in <= seed[16];
      ri(seed[10:8] % 7);
      chk(ch2_current_code_out, {sh[1][1:0], sh[2]}, "ch2 code");
      chk(ch1_current_code_out, {sh[5][1:0], sh[6]}, "ch1 code");
    end
    for (int k = 0; k < 8; k++) begin
      low_power_select_n_in <= k[0];
      wi(k[0] ? 3 : 4, fsc[k / 2]);
      wi(k[0] ? 4 : 3, ~fsc[k / 2]);
      settle(4);
      chk(ch2_fullscale_ma_out, fma[k / 2], "full scale");
      chk(ch2_fullscale_field_out, fsc[k / 2], "scale sel");
    end
    for (int k = 0; k < 4; k++) begin
      wi(0, 8'(k << 4) | 8'(k << 1) | 8'h01);
      settle(2);
      chk(ch2_alarm_trip_mv_out, mvs[k], "trip mv");
      chk(ch2_alarm_trip_level_out, k, "trip level");
      chk(ch2_alarm_turnon_delay_out, k, "turnon delay");
    end
    for (int k = 0; k < 2; k++) begin
      wi(0, k ? 8'h08 : 8'h00);
      ch2_alarm_trip_in <= 1'b1;
      n = 0;
      while (ch2_alarm_out !== 1'b1 && n < 300) begin
        settle(1);
        n++;
      end
      chk(n >= (k ? 200 : 80) && n <= (k ? 210 : 90), 1,
          "alarm delay");
      ch2_alarm_trip_in <= 1'b0;
      settle(10);
    end
    wi(0, 8'h00);
    ch2_alarm_trip_in <= 1'b1;
    settle(100);
    wi(0, 8'h01);
    settle(3);
    chk(ch2_alarm_out, 1'b0, "powerdown");
    settle(120);
    chk(ch2_alarm_out, 1'b0, "held down");
    finish_test();
  end
endmodule
bind ldar_regs ldar_regs_monitor mon_u (.sys_clk_in, .rst_in, .reg_addr_in,
  .reg_wr_in, .reg_wdata_in, .low_power_select_n_in, .ch2_alarm_trip_in,
  .ch2_current_code_out, .ch2_fullscale_field_out, .ch2_fullscale_ma_out,
  .ch2_alarm_trip_level_out, .ch2_alarm_trip_mv_out,
  .ch2_alarm_filter_sel_out, .ch2_alarm_powerdown_out, .ch2_alarm_out);
`default_nettype wire
